// ### ccp_ctrl_port.sv
// Purpose: Serial control port: two-wire slave, 16-bit SPI, 24-bit SPI.
// Assumes: Host holds sclk still while chip_select_n is high.
// Notes:   SPI shifting and wide-frame decode run on sclk; writes run on clk.
`timescale 1ns/100ps
module ccp_ctrl_port
	import ccp_pkg::*;
(
	input  wire logic               clk,             // System clock
	input  wire logic               rst_n,           // Async reset, low
	input  wire logic               sclk,            // Host serial clock
	input  wire logic               chip_select_n,   // SPI frame select
	input  wire logic               sdio_in,         // Data pin level
	output logic                    sdio_out,        // Data pin drive
	output logic                    sdio_oe_n,       // Low while driving
	input  wire logic               mode_sel,        // Interface pin
	output logic                    reg_wr_en,       // Write pulse
	output ccp_wr_t                 reg_wr,          // Write address/data
	output logic [ADDR_W-1:0]       reg_rd_addr,     // Read pointer
	input  wire logic [DATA_W-1:0]  reg_rd_data,     // Read data
	output logic                    wide_spi_enable  // Wide SPI bit
);

	////////////////////////////////////////////////////////////////////
	// Link domain: shifting on the host clock

	logic [FRM24_W-1:0] sh_reg;
	logic [4:0]         hcnt_reg;
	logic [3:0]         bcnt_reg;
	logic               seen16_reg;
	logic               dev_ok_reg;
	logic [ADDR_W-1:0]  wptr_reg;
	ccp_wr_t            pub_reg;
	logic               pub_tg_reg;
	logic               link_rst;
	logic [DATA_W-1:0]  nine;

	// Frame counters restart whenever the frame is not selected
	assign link_rst = chip_select_n || !rst_n;
	assign nine = {sh_reg[7:0], sdio_in};

	// Shifter keeps its bits across sclk pauses and after the frame
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			sh_reg <= '0;
		end else begin
			sh_reg <= {sh_reg[FRM24_W-2:0], sdio_in};
		end
	end

	// Bit position within the frame and within each data block
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			hcnt_reg <= '0;
			bcnt_reg <= '0;
		end else if (hcnt_reg != CNT_24_DONE) begin
			hcnt_reg <= hcnt_reg + 5'h01;
		end else if (bcnt_reg == CNT_BLK_LAST) begin
			bcnt_reg <= '0;
		end else begin
			bcnt_reg <= bcnt_reg + 4'h1;
		end
	end

	// Marks that a full 16-bit frame has arrived
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			seen16_reg <= 1'b0;
		end else if (hcnt_reg == CNT_16_LAST) begin
			seen16_reg <= 1'b1;
		end else if (hcnt_reg == '0) begin
			seen16_reg <= 1'b0;
		end
	end

	// Wide frame decode: device byte check, address, bursts
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			dev_ok_reg <= 1'b0;
			wptr_reg   <= '0;
			pub_reg    <= '0;
			pub_tg_reg <= 1'b1; // Matches synchroniser preset, no false event
		end else if (hcnt_reg == CNT_DEV_LAST) begin
			dev_ok_reg <= ({sh_reg[6:0], sdio_in} == SPI_DEV_WR);
		end else if (hcnt_reg == CNT_24_LAST) begin
			wptr_reg <= sh_reg[14:8];
			if (dev_ok_reg) begin
				pub_reg    <= '{addr: sh_reg[14:8], data: nine};
				pub_tg_reg <= ~pub_tg_reg;
			end
		end else if (hcnt_reg == CNT_24_DONE && bcnt_reg == CNT_BLK_LAST) begin
			wptr_reg <= wptr_reg + 7'h01;
			if (dev_ok_reg) begin
				pub_reg    <= '{addr: wptr_reg + 7'h01, data: nine};
				pub_tg_reg <= ~pub_tg_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// System domain: pin synchronisers

	localparam int NSYNC = 5;
	logic [NSYNC-1:0] sy_in;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] s3_reg;
	logic [NSYNC-1:0] acc_reg;
	logic [NSYNC-1:0] prev_reg;

	assign sy_in = {pub_tg_reg, mode_sel, chip_select_n, sdio_in, sclk};

	// Three stages; a level counts once stages two and three agree
	generate
		for (genvar i = 0; i < NSYNC; i++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg[i]   <= 1'b1;
					s2_reg[i]   <= 1'b1;
					s3_reg[i]   <= 1'b1;
					acc_reg[i]  <= 1'b1;
					prev_reg[i] <= 1'b1;
				end else begin
					s1_reg[i]   <= sy_in[i];
					s2_reg[i]   <= s1_reg[i];
					s3_reg[i]   <= s2_reg[i];
					prev_reg[i] <= acc_reg[i];
					if (s2_reg[i] == s3_reg[i]) begin
						acc_reg[i] <= s3_reg[i];
					end
				end
			end
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic tw_start;
	logic tw_stop;
	logic cs_rise;
	logic pub_evt;

	// Edges of the accepted levels
	assign scl_s    = acc_reg[0];
	assign sda_s    = acc_reg[1];
	assign scl_rise = acc_reg[0] && !prev_reg[0];
	assign scl_fall = !acc_reg[0] && prev_reg[0];
	assign tw_start = scl_s && prev_reg[0] && prev_reg[1] && !sda_s;
	assign tw_stop  = scl_s && prev_reg[0] && !prev_reg[1] && sda_s;
	assign cs_rise  = acc_reg[2] && !prev_reg[2];
	assign pub_evt  = acc_reg[4] != prev_reg[4];

	////////////////////////////////////////////////////////////////////
	// Protocol selection

	ccp_mode_t mode;

	always_comb begin
		if (wide_spi_enable) begin
			mode = MODE_SPI24;
		end else if (acc_reg[3]) begin
			mode = MODE_SPI16;
		end else begin
			mode = MODE_TWO_WIRE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Two-wire slave

	ccp_tw_state_t     tw_st_reg;
	ccp_tw_state_t     tw_nx_reg;
	logic [3:0]        tw_bit_reg;
	logic [7:0]        tw_sh_reg;
	logic [ADDR_W-1:0] tw_ptr_reg;
	logic              tw_d8_reg;
	logic              tw_half_reg;
	logic              tw_wr_reg;
	logic              tw_rcv;
	logic [7:0]        tx_byte;

	assign tw_rcv  = tw_st_reg == TW_DEV || tw_st_reg == TW_REG || tw_st_reg == TW_DLO;
	// Upper byte carries data bit 8, lower byte the rest
	assign tx_byte = tw_half_reg ? reg_rd_data[7:0] : {7'h00, reg_rd_data[8]};

	// Byte engine, acknowledge and read-out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tw_st_reg   <= TW_IDLE;
			tw_nx_reg   <= TW_IDLE;
			tw_bit_reg  <= '0;
			tw_sh_reg   <= '0;
			tw_ptr_reg  <= '0;
			tw_d8_reg   <= 1'b0;
			tw_half_reg <= 1'b0;
			tw_wr_reg   <= 1'b0;
			sdio_oe_n   <= 1'b1;
		end else begin
			tw_wr_reg <= 1'b0;
			if (tw_stop || mode != MODE_TWO_WIRE) begin
				tw_st_reg <= TW_IDLE;
				sdio_oe_n <= 1'b1;
			end else if (tw_start) begin
				tw_st_reg  <= TW_DEV;
				tw_bit_reg <= '0;
				sdio_oe_n  <= 1'b1;
			end else begin
				unique case (tw_st_reg)
					TW_IDLE: begin
						sdio_oe_n <= 1'b1;
					end
					TW_DEV, TW_REG, TW_DLO: begin
						if (scl_rise && tw_rcv && tw_bit_reg != CNT_BYTE) begin
							tw_sh_reg  <= {tw_sh_reg[6:0], sda_s};
							tw_bit_reg <= tw_bit_reg + 4'h1;
						end else if (scl_fall && tw_bit_reg == CNT_BYTE) begin
							tw_bit_reg <= '0;
							tw_st_reg  <= TW_ACK;
							sdio_oe_n  <= 1'b0;
							if (tw_st_reg == TW_DEV) begin
								if (tw_sh_reg[7:1] != TW_SLAVE_ADDR) begin
									tw_st_reg <= TW_IDLE;
									sdio_oe_n <= 1'b1;
								end
								tw_half_reg <= 1'b0;
								tw_nx_reg   <= tw_sh_reg[0] ? TW_LOAD : TW_REG;
							end else if (tw_st_reg == TW_REG) begin
								tw_ptr_reg <= tw_sh_reg[7:1];
								tw_d8_reg  <= tw_sh_reg[0];
								tw_nx_reg  <= TW_DLO;
							end else begin
								tw_wr_reg <= 1'b1;
								tw_nx_reg <= TW_IDLE;
							end
						end
					end
					TW_ACK: begin
						if (scl_fall) begin
							sdio_oe_n <= 1'b1;
							tw_st_reg <= tw_nx_reg;
						end
					end
					TW_LOAD: begin
						tw_bit_reg <= '0;
						sdio_oe_n  <= tx_byte[7];
						tw_st_reg  <= TW_TX;
					end
					TW_TX: begin
						if (scl_fall) begin
							tw_bit_reg <= tw_bit_reg + 4'h1;
							if (tw_bit_reg == CNT_BYTE_LAST) begin
								sdio_oe_n <= 1'b1;
								tw_st_reg <= TW_MACK;
							end else begin
								sdio_oe_n <= tx_byte[3'(6 - tw_bit_reg)];
							end
						end
					end
					TW_MACK: begin
						if (scl_rise && sda_s) begin
							tw_st_reg <= TW_IDLE;
						end else if (scl_fall) begin
							tw_half_reg <= ~tw_half_reg;
							if (tw_half_reg) begin
								tw_ptr_reg <= tw_ptr_reg + 7'h01;
							end
							tw_st_reg <= TW_LOAD;
						end
					end
				endcase
			end
		end
	end

	// Open-drain data: only ever pulls low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sdio_out <= 1'b0;
		end else begin
			sdio_out <= 1'b0;
		end
	end

	// Read pointer faces the register file
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rd_addr <= '0;
		end else begin
			reg_rd_addr <= tw_ptr_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register write merge

	logic    wr_go;
	ccp_wr_t wr_word;

	// One source per mode; 16-bit SPI has no read path
	always_comb begin
		wr_go   = 1'b0;
		wr_word = '0;
		unique case (mode)
			MODE_SPI24: begin
				wr_go   = pub_evt;
				wr_word = pub_reg;
			end
			MODE_SPI16: begin
				wr_go   = cs_rise && seen16_reg;
				wr_word = '{addr: sh_reg[15:9], data: sh_reg[8:0]};
			end
			MODE_TWO_WIRE: begin
				wr_go   = tw_wr_reg;
				wr_word = '{addr: tw_ptr_reg, data: {tw_d8_reg, tw_sh_reg}};
			end
		endcase
	end

	// Write strobe and value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_wr_en <= 1'b0;
			reg_wr    <= '0;
		end else begin
			reg_wr_en <= wr_go;
			if (wr_go) begin
				reg_wr <= wr_word;
			end
		end
	end

	// Wide enable follows writes to the interface register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wide_spi_enable <= WIDE_RST;
		end else if (wr_go && wr_word.addr == REG_IFACE) begin
			wide_spi_enable <= wr_word.data[WIDE_BIT];
		end
	end

endmodule

// ### ccp_pkg.sv
// Purpose: Shared constants and types for the codec control port.
// Assumes: 9-bit control registers with 7-bit addresses.
// Notes:   Included by the control port through a wildcard import.
package ccp_pkg;

	// Field widths
	localparam int ADDR_W = 7;
	localparam int DATA_W = 9;
	localparam int FRM16_W = 16;
	localparam int FRM24_W = 24;

	// Fixed addresses and control bit position
	localparam logic [7:0] SPI_DEV_WR = 8'h10;
	localparam logic [6:0] TW_SLAVE_ADDR = 7'h1A;
	localparam logic [6:0] REG_IFACE = 7'h49;
	localparam int WIDE_BIT = 8;

	// Frame bit positions (counted from zero at the first bit)
	localparam logic [4:0] CNT_DEV_LAST = 5'h07;
	localparam logic [4:0] CNT_16_LAST = 5'h0F;
	localparam logic [4:0] CNT_24_LAST = 5'h17;
	localparam logic [4:0] CNT_24_DONE = 5'h18;
	localparam logic [3:0] CNT_BLK_LAST = 4'h8;
	localparam logic [3:0] CNT_BYTE = 4'h8;
	localparam logic [3:0] CNT_BYTE_LAST = 4'h7;

	// Reset values
	localparam logic WIDE_RST = 1'b0;

	// Protocol in force
	typedef enum logic [1:0] {
		MODE_TWO_WIRE,
		MODE_SPI16,
		MODE_SPI24
	} ccp_mode_t;

	// Two-wire slave states
	typedef enum logic [2:0] {
		TW_IDLE,
		TW_DEV,
		TW_REG,
		TW_DLO,
		TW_ACK,
		TW_LOAD,
		TW_TX,
		TW_MACK
	} ccp_tw_state_t;

	// One register write
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ccp_wr_t;

endpackage

// ### ccp_props.sv
// Purpose: Port checker for the codec control port.
// Assumes: Host keeps sclk idle high and still outside frames.
// Notes:   Bound to the control port from the testbench file.
`timescale 1ns/100ps
module ccp_props
	import ccp_pkg::*;
(
	input wire logic              clk,             // System clock
	input wire logic              rst_n,           // Async reset, low
	input wire logic              sclk,            // Host serial clock
	input wire logic              chip_select_n,   // Frame select
	input wire logic              sdio_in,         // Data pin level
	input wire logic              sdio_out,        // Data pin drive
	input wire logic              sdio_oe_n,       // Low while driving
	input wire logic              mode_sel,        // Interface pin
	input wire logic              reg_wr_en,       // Write pulse
	input wire ccp_wr_t           reg_wr,          // Write address/data
	input wire logic [ADDR_W-1:0] reg_rd_addr,     // Read pointer
	input wire logic [DATA_W-1:0] reg_rd_data,     // Read data
	input wire logic              wide_spi_enable  // Wide SPI bit
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Pin behaviour
	property p_open_drain; sdio_out == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
	property p_drive_scl_low; $changed(sdio_oe_n) |-> !sclk; endproperty
	a_drive_scl_low: assert property (p_drive_scl_low) else $error("data changed with clock high");
	property p_ack_hold; $fell(sdio_oe_n) |=> !sdio_oe_n [*4]; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("pull low too short");
	property p_spi_quiet; (wide_spi_enable || mode_sel) |-> sdio_oe_n; endproperty
	a_spi_quiet: assert property (p_spi_quiet) else $error("driven in spi mode");
	////////////////////////////////////////////////////////////////////////////////
	// Writes and mode
	property p_wen_pulse; reg_wr_en |=> !reg_wr_en; endproperty
	a_wen_pulse: assert property (p_wen_pulse) else $error("write pulse too long");
	property p_wr_hold; !reg_wr_en |-> $stable(reg_wr); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write value moved");
	property p_cs_commit; reg_wr_en && mode_sel && !wide_spi_enable |-> chip_select_n; endproperty
	a_cs_commit: assert property (p_cs_commit) else $error("write before select rise");
	property p_wide_src;
		$changed(wide_spi_enable) |-> reg_wr.addr == REG_IFACE && wide_spi_enable == reg_wr.data[WIDE_BIT];
	endproperty
	a_wide_src: assert property (p_wide_src) else $error("wide bit moved alone");
	property p_rd_ptr; $changed(reg_rd_addr) |-> !mode_sel && !wide_spi_enable; endproperty
	a_rd_ptr: assert property (p_rd_ptr) else $error("pointer moved in spi mode");
endmodule

// ### ccp_host.sv
// Purpose: Host master model for SPI and two-wire frames.
// Assumes: Data line has a pull-up; sclk idles high.
// Notes:   Tasks are called from the testbench.
`timescale 1ns/100ps
module ccp_host (
	output logic      sclk,          // Serial clock
	output logic      chip_select_n, // Frame select
	output logic      sdio,          // Data line level
	input  wire logic sdio_out,      // Device drive value
	input  wire logic sdio_oe_n      // Device drive enable
);
	logic d; // Host drive level
	initial begin
		sclk = 1'b1;
		chip_select_n = 1'b1;
		d = 1'b1;
	end
	// Wire level: pulled up unless a party pulls low
	assign sdio = d & (sdio_oe_n | sdio_out);
	// SPI frame of n bits, optional pause after bit p
	task automatic spi(input int n, input logic [35:0] v, input int p);
		chip_select_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#3 sclk = 1'b0;
			d = v[i];
			#3 sclk = 1'b1;
			if (i == p) #200;
		end
		#60 chip_select_n = 1'b1;
		d = ~d;
		#60;
	endtask
	// Start is (1,0), stop is (0,1)
	task automatic tw_cond(input logic a, input logic b);
		#50 d = a;
		#50 sclk = 1'b1;
		#50 d = b;
		#50 sclk = b;
	endtask
	// Eight bits then the ninth, MSB first; r samples the wire
	task automatic tw_byte(input logic [8:0] b, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			#25 d = b[i];
			#25 sclk = 1'b1;
			#50 r[i] = sdio;
			sclk = 1'b0;
		end
	endtask
endmodule

// ### ccp_tb.sv
// Purpose: Self-checking bench for the codec control port.
// Assumes: Register contents are modelled from the read pointer.
// Notes:   Writes are logged into a queue and judged per scenario.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((e) !== (a)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, a); end end
module testbench;
	import ccp_pkg::*;
	logic              clk = 1'b0;
	logic              rst_n, mode_sel, sclk, chip_select_n, sdio, sdio_out, sdio_oe_n, reg_wr_en, wide_spi_enable;
	ccp_wr_t           reg_wr;
	logic [ADDR_W-1:0] reg_rd_addr;
	logic [DATA_W-1:0] reg_rd_data;
	logic [8:0]        r;
	ccp_wr_t           q[$];
	int                mismatches = 0, n_tests = 0, cyc = 0;
	always #2.5 clk = ~clk;
	// Register file stand-in
	assign reg_rd_data = {~reg_rd_addr[0], 1'b1, reg_rd_addr};
	ccp_ctrl_port DUT (.clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n), .sdio_in(sdio),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .mode_sel(mode_sel), .reg_wr_en(reg_wr_en), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .wide_spi_enable(wide_spi_enable));
	ccp_host host (.sclk(sclk), .chip_select_n(chip_select_n), .sdio(sdio), .sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n));
	////////////////////////////////////////////////////////////////////////////////
	// Write log and run limit
	always @(negedge clk) begin
		if (reg_wr_en === 1'b1)
			q.push_back(reg_wr);
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done;
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_wr(input int k, input ccp_wr_t e0, input ccp_wr_t e1);
		repeat (10) @(negedge clk);
		`CHK("write count", k, q.size())
		if (k > 0 && q.size() > 0) `CHK("first write", e0, q[0])
		if (k > 1 && q.size() > 1) `CHK("second write", e1, q[1])
		q.delete();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_spi16;
		host.spi(20, {16'h0, 4'hF, 7'h12, 9'h1A5}, 9);
		host.spi(10, 36'h2AA, -1);
		chk_wr(1, {7'h12, 9'h1A5}, '0);
	endtask
	task automatic t_wide;
		host.spi(16, {20'h0, 7'h49, 9'h100}, -1);
		chk_wr(1, {7'h49, 9'h100}, '0);
		`CHK("wide on", 1'b1, wide_spi_enable)
		@(negedge clk) mode_sel = 1'b0;
		repeat (8) @(negedge clk);
		host.spi(33, {3'h0, 8'h10, 7'h7F, 9'h0AB, 9'h155}, -1);
		chk_wr(2, {7'h7F, 9'h0AB}, {7'h00, 9'h155});
		host.spi(24, {12'h0, 8'h11, 7'h05, 9'h1FF}, -1);
		chk_wr(0, '0, '0);
		host.spi(24, {12'h0, 8'h10, 7'h49, 9'h000}, -1);
		chk_wr(1, {7'h49, 9'h000}, '0);
		`CHK("wide off", 1'b0, wide_spi_enable)
	endtask
	task automatic t_tw;
		logic [7:0] rd_exp [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};
		host.tw_cond(1'b1, 1'b0);
		host.tw_byte({8'h34, 1'b1}, r);
		`CHK("address ack", 1'b0, r[0])
		host.tw_byte({7'h05, 1'b1, 1'b1}, r);
		host.tw_byte({8'h5A, 1'b1}, r);
		`CHK("data ack", 1'b0, r[0])
		host.tw_cond(1'b0, 1'b1);
		chk_wr(1, {7'h05, 9'h15A}, '0);
		host.tw_cond(1'b1, 1'b0);
		host.tw_byte({8'h36, 1'b1}, r);
		`CHK("foreign nack", 1'b1, r[0])
		host.tw_cond(1'b0, 1'b1);
		chk_wr(0, '0, '0);
		host.tw_cond(1'b1, 1'b0);
		host.tw_byte({8'h34, 1'b1}, r);
		host.tw_byte({7'h7F, 1'b0, 1'b1}, r);
		host.tw_cond(1'b1, 1'b0);
		host.tw_byte({8'h35, 1'b1}, r);
		foreach (rd_exp[i]) begin
			host.tw_byte({8'hFF, i == 3}, r);
			`CHK("read byte", rd_exp[i], r[8:1])
		end
		host.tw_cond(1'b0, 1'b1);
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		mode_sel = 1'b1;
		repeat (5) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("wide reset", 1'b0, wide_spi_enable)
		t_spi16;
		t_wide;
		t_tw;
		test_done;
	end
endmodule
bind ccp_ctrl_port ccp_props u_props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n),
	.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .mode_sel(mode_sel), .reg_wr_en(reg_wr_en),
	.reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .wide_spi_enable(wide_spi_enable));
